/* File: hdl/irq_ctrl_defines.svh */
// Offsets, field positions and constants of the interrupt controller.
`ifndef IRQ_CTRL_DEFINES_SVH
`define IRQ_CTRL_DEFINES_SVH

// Register byte offsets on the AXI4-Lite bus.
`define OFS_IRQ_CONTROL       8'h00
`define OFS_PIN_CHANGE_FLAGS  8'h04
`define OFS_FALL_DETECT_EN    8'h08
`define OFS_RISE_DETECT_EN    8'h0C
`define OFS_PERIPH_IRQ_EN     8'h10
`define OFS_PERIPH_REQ_FLAGS  8'h14
`define OFS_CORE_CONFIG       8'h18
`define OFS_CORE_STATUS       8'h1C

// Field positions in irq_control.
`define BIT_GIE   7
`define BIT_PERIPHERAL_GROUP_ENABLE  6
`define BIT_TOIE  5
`define BIT_EXIE  4
`define BIT_PCIE  3
`define BIT_TOIF  2
`define BIT_EXIF  1
`define BIT_PCIF  0

// Field positions in core_config, counted from bit 6 above the analog selects.
`define BIT_EDGE_SEL  0

// Masks of implemented bits.
`define PIN_MASK     8'h3F
`define PERIPH_MASK  8'hCF

// Reset values.
`define RST_BYTE      8'h00
`define RST_ANALOG    6'h3F

// Interrupt vector address.
`define IRQ_VECTOR    13'h0004

// Counter roll-over value.
`define TICK_MAX      8'hFF

// AXI responses.
`define RESP_OKAY     2'b00
`define RESP_SLVERR   2'b10

`endif

/* File: hdl/irq_ctrl_pkg.sv */
// Types shared by the interrupt controller.
package irq_ctrl_pkg;

    // Instruction-sequencer request to the core.
    typedef struct packed {
        logic        take;
        logic [12:0] vector;
    } core_req_s;

    // Acceptance state.
    typedef enum logic [1:0] {
        ST_RUN   = 2'b00,
        ST_SLEEP = 2'b01,
        ST_WAKE  = 2'b10
    } run_state_e;

endpackage : irq_ctrl_pkg

/* File: hdl/cpu_interrupt_controller.sv */
// Interrupt controller of a small 8-bit processor core with AXI4-Lite registers.
//
// Summary of operation
// - Requests reach core only while global enable set.
// - Reset clears the global enable.
// - Accept clears enable, pushes return, vectors 0004h.
// - Return-from-interrupt sets the global enable again.
// - Flags set regardless of any enable.
// - Enable-clearing instruction suppresses next-cycle take; pending.
// - External event latency is three or four cycles.
// - Edge pin polarity chosen by edge select.
// - Valid edge sets pin flag; enable gates it.
// - Pin interrupt wakes sleep if enabled before.
// - Analog pins read zero and never interrupt.
// - Counter rollover FFh to 00h sets overflow flag.
// - Selected pin change sets change flag, gated.
// - Change during port operation may be missed.
// - Pin flag may set during Q4-Q1 phases.
// - Control register bit order fixed, global at 7.
// - Peripheral flags at bits 7,6,3,2,1,0 with enables.
// - Sleep wake runs PC+1, vectors only if enabled.
// - Only return address saved by hardware.
`timescale 1ns/100ps
`include "irq_ctrl_defines.svh"
`default_nettype none

module cpu_interrupt_controller
    import irq_ctrl_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite slave.
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Port pins; bit 2 carries the external interrupt pin.
    input  wire logic [5:0]  port_pins,
    // Event pulses from timers and peripherals (same clock).
    input  wire logic        tick_rollover,
    input  wire logic [5:0]  periph_events,
    input  wire logic        port_op_busy,
    // Core sequencer handshake.
    input  wire logic [12:0] core_pc,
    input  wire logic        core_gie_clear,
    input  wire logic        core_return_from_isr_instruction,
    input  wire logic        core_sleep,
    input  wire logic        core_ack,
    output logic             core_take_ff,
    output logic [12:0]      core_vector_ff,
    output logic             core_push_ff,
    output logic [12:0]      core_return_ff,
    output logic             core_wake_ff,
    output logic             core_asleep_ff
);

    // ========================================================================
    // State registers.
    // ========================================================================
    logic [7:0]  irq_control_ff;
    logic [5:0]  pin_change_flags_ff;
    logic [5:0]  fall_en_ff;
    logic [5:0]  rise_en_ff;
    logic [7:0]  periph_irq_enables_ff;
    logic [7:0]  periph_request_flags_ff;
    logic [5:0]  analog_select_ff;
    logic        ext_edge_select_ff;
    logic [5:0]  pin_meta_ff;
    logic [5:0]  pin_sync_ff;
    logic [5:0]  pin_prev_ff;
    logic        gie_block_ff;
    run_state_e  state_ff;

    // ========================================================================
    // Pin synchronisation and edge detection.
    // ========================================================================
    // Analog pins read as zero so they never produce an edge.
    wire logic [5:0] pin_digital = pin_sync_ff & ~analog_select_ff;
    wire logic [5:0] pin_rise    = pin_digital & ~pin_prev_ff;
    wire logic [5:0] pin_fall    = ~pin_digital & pin_prev_ff;
    // A change during a port operation is dropped.
    wire logic [5:0] pin_chg_set = ((pin_rise & rise_en_ff) | (pin_fall & fall_en_ff))
                                   & {6{~port_op_busy}};
    // The pin flag may set in any cycle, covering all instruction phases.
    wire logic ext_edge = ext_edge_select_ff ? pin_rise[2] : pin_fall[2];

    // Two flip-flops bring the pins into the clock domain; a third keeps the last level.
    always_ff @(posedge aclk) begin
        pin_meta_ff <= port_pins;
        pin_sync_ff <= pin_meta_ff;
        pin_prev_ff <= pin_digital;
    end

    // ========================================================================
    // Request gating.
    // ========================================================================
    wire logic global_irq_enable     = irq_control_ff[`BIT_GIE];
    wire logic pc_flag = |pin_change_flags_ff;
    wire logic periph_any = |(periph_request_flags_ff & periph_irq_enables_ff);
    wire logic periph_req = periph_any & irq_control_ff[`BIT_PERIPHERAL_GROUP_ENABLE];
    wire logic ext_req = irq_control_ff[`BIT_EXIE] & irq_control_ff[`BIT_EXIF];
    wire logic tick_req = irq_control_ff[`BIT_TOIE] & irq_control_ff[`BIT_TOIF];
    wire logic chg_req  = irq_control_ff[`BIT_PCIE] & pc_flag;
    wire logic any_req  = ext_req | tick_req | chg_req | periph_req;
    // Global enable gates all; a just-executed clear blocks the next cycle.
    wire logic take_now = any_req & global_irq_enable & ~gie_block_ff & ~core_gie_clear
                          & ~core_take_ff & (state_ff == ST_RUN);

    // ========================================================================
    // AXI4-Lite decode.
    // ========================================================================
    logic        aw_held_ff;
    logic        w_held_ff;
    logic [7:0]  aw_addr_ff;
    logic [31:0] w_data_ff;
    logic [3:0]  w_strb_ff;
    wire logic   wr_fire = aw_held_ff & w_held_ff & ~s_axi_bvalid;
    wire logic   wr_lane = w_strb_ff[0];
    wire logic [7:0] wd  = w_data_ff[7:0];
    wire logic   wr_ctl  = wr_fire & wr_lane & (aw_addr_ff == `OFS_IRQ_CONTROL);
    wire logic   wr_pcf  = wr_fire & wr_lane & (aw_addr_ff == `OFS_PIN_CHANGE_FLAGS);
    wire logic   wr_fen  = wr_fire & wr_lane & (aw_addr_ff == `OFS_FALL_DETECT_EN);
    wire logic   wr_ren  = wr_fire & wr_lane & (aw_addr_ff == `OFS_RISE_DETECT_EN);
    wire logic   wr_pie  = wr_fire & wr_lane & (aw_addr_ff == `OFS_PERIPH_IRQ_EN);
    wire logic   wr_pir  = wr_fire & wr_lane & (aw_addr_ff == `OFS_PERIPH_REQ_FLAGS);
    wire logic   wr_cfg  = wr_fire & wr_lane & (aw_addr_ff == `OFS_CORE_CONFIG);
    wire logic   wr_hit  = (aw_addr_ff <= `OFS_CORE_CONFIG) & (aw_addr_ff[1:0] == 2'b00);

    // Write channel: hold address and data, answer once both are in.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_ff   <= 1'b0;
            w_held_ff    <= 1'b0;
            aw_addr_ff   <= 8'h00;
            w_data_ff    <= 32'h00000000;
            w_strb_ff    <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_ff <= 1'b1;
                aw_addr_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_ff <= 1'b1;
                w_data_ff <= s_axi_wdata;
                w_strb_ff <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_held_ff   <= 1'b0;
                w_held_ff    <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Ready outputs are registered: high while that channel is empty.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
        end else begin
            s_axi_awready <= ~aw_held_ff & ~(s_axi_awvalid & s_axi_awready);
            s_axi_wready  <= ~w_held_ff & ~(s_axi_wvalid & s_axi_wready);
        end
    end

    // Read mux.
    logic [7:0] rd_byte;
    logic       rd_hit;
    always_comb begin
        rd_byte = 8'h00;
        rd_hit  = 1'b1;
        case (s_axi_araddr)
            `OFS_IRQ_CONTROL:      rd_byte = irq_control_ff;
            `OFS_PIN_CHANGE_FLAGS: rd_byte = {2'b00, pin_change_flags_ff};
            `OFS_FALL_DETECT_EN:   rd_byte = {2'b00, fall_en_ff};
            `OFS_RISE_DETECT_EN:   rd_byte = {2'b00, rise_en_ff};
            `OFS_PERIPH_IRQ_EN:    rd_byte = periph_irq_enables_ff;
            `OFS_PERIPH_REQ_FLAGS: rd_byte = periph_request_flags_ff;
            `OFS_CORE_CONFIG:      rd_byte = {1'b0, ext_edge_select_ff, analog_select_ff};
            `OFS_CORE_STATUS:      rd_byte = {pin_digital, state_ff};
            default:               rd_hit  = 1'b0;
        endcase
    end

    // Read channel: one-cycle registered answer.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `RESP_OKAY;
        end else begin
            s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready & s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= {24'h000000, rd_byte};
                s_axi_rresp  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ========================================================================
    // Control and flag registers; hardware set wins over software clear.
    // ========================================================================
    wire logic [5:0] pin_change_flags_nxt =
        6'(((wr_pcf ? wd[5:0] : pin_change_flags_ff) | pin_chg_set) & `PIN_MASK);
    wire logic [7:0] ctl_sw = wr_ctl ? wd : irq_control_ff;
    wire logic gie_next = take_now ? 1'b0 :
                          core_return_from_isr_instruction ? 1'b1 :
                          core_gie_clear ? 1'b0 : ctl_sw[`BIT_GIE];
    wire logic [7:0] ctl_next = {gie_next, ctl_sw[6:3],
                                 ctl_sw[`BIT_TOIF] | tick_rollover,
                                 ctl_sw[`BIT_EXIF] | ext_edge,
                                 |(pin_change_flags_nxt)};
    wire logic [7:0] periph_flags_nxt =
        ((wr_pir ? wd : periph_request_flags_ff)
         | {periph_events[5:4], 2'b00, periph_events[3:0]}) & `PERIPH_MASK;

    // Register updates.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_control_ff          <= `RST_BYTE;
            pin_change_flags_ff     <= 6'h00;
            fall_en_ff              <= 6'h00;
            rise_en_ff              <= 6'h00;
            periph_irq_enables_ff   <= `RST_BYTE;
            periph_request_flags_ff <= `RST_BYTE;
            analog_select_ff        <= `RST_ANALOG;
            ext_edge_select_ff      <= 1'b1;
            gie_block_ff            <= 1'b0;
        end else begin
            irq_control_ff          <= ctl_next;
            pin_change_flags_ff     <= pin_change_flags_nxt;
            periph_request_flags_ff <= periph_flags_nxt;
            gie_block_ff            <= core_gie_clear;
            if (wr_fen) fall_en_ff <= wd[5:0];
            if (wr_ren) rise_en_ff <= wd[5:0];
            if (wr_pie) periph_irq_enables_ff <= wd & `PERIPH_MASK;
            if (wr_cfg) begin
                analog_select_ff   <= wd[5:0];
                ext_edge_select_ff <= wd[`BIT_EDGE_SEL + 6];
            end
        end
    end

    // ========================================================================
    // Acceptance, sleep and wake sequencing.
    // ========================================================================
    // Sync (2) + flag (1) + take (1) gives three or four cycles to vector.
    wire logic wake_src = any_req; // enable must already be set
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_ff       <= ST_RUN;
            core_take_ff   <= 1'b0;
            core_vector_ff <= 13'h0000;
            core_push_ff   <= 1'b0;
            core_return_ff <= 13'h0000;
            core_wake_ff   <= 1'b0;
            core_asleep_ff <= 1'b0;
        end else begin
            core_push_ff <= 1'b0;
            core_wake_ff <= 1'b0;
            if (take_now) begin
                core_take_ff   <= 1'b1;
                core_vector_ff <= `IRQ_VECTOR;
                core_push_ff   <= 1'b1;
                core_return_ff <= core_pc;
            end else if (core_ack) begin
                core_take_ff <= 1'b0;
            end
            case (state_ff)
                ST_RUN: begin
                    if (core_sleep && !take_now) begin
                        state_ff       <= wake_src ? ST_WAKE : ST_SLEEP;
                        core_asleep_ff <= ~wake_src;
                    end
                end
                ST_SLEEP: begin
                    if (wake_src) begin
                        state_ff       <= ST_WAKE;
                        core_asleep_ff <= 1'b0;
                    end
                end
                ST_WAKE: begin
                    // Core runs PC+1; the vector follows only if enabled.
                    core_wake_ff <= 1'b1;
                    state_ff     <= ST_RUN;
                end
                default: state_ff <= ST_RUN;
            endcase
        end
    end

endmodule : cpu_interrupt_controller

`default_nettype wire

/* File: bench/core_seq_model.sv */
// Behavioural model of the core sequencer facing the controller.
`timescale 1ns/100ps
`include "irq_ctrl_defines.svh"
`default_nettype none

// ====================================
// Core sequencer model
module core_seq_model (
    input  wire logic   aclk,
    input  wire logic   aresetn,
    input  wire logic   slow,
    input  wire logic   core_take_ff,
    output logic        core_ack,
    output logic [12:0] core_pc,
    output int          take_cnt
);
    int wait_cnt;

    // Steps the program counter and accepts a vector after a short or a long stall.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            core_pc  <= 13'h0100;
            core_ack <= 1'b0;
            wait_cnt <= 0;
            take_cnt <= 0;
        end else begin
            core_pc  <= core_pc + 13'h0001;
            core_ack <= 1'b0;
            wait_cnt <= 0;
            if (core_take_ff && !core_ack) begin
                wait_cnt <= wait_cnt + 1;
                if (wait_cnt >= (slow ? 5 : 0)) begin
                    core_ack <= 1'b1;
                    take_cnt <= take_cnt + 1;
                    core_pc  <= `IRQ_VECTOR;
                end
            end
        end
    end
endmodule : core_seq_model

`default_nettype wire

/* File: bench/irq_ctrl_assertions.sv */
// Port assertions of the interrupt controller.
`timescale 1ns/100ps
`include "irq_ctrl_defines.svh"
`default_nettype none

// ====================================
// Checker
module irq_ctrl_checker (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_rvalid,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic [12:0] core_pc,
    input wire logic        core_gie_clear,
    input wire logic        core_ack,
    input wire logic        core_take_ff,
    input wire logic [12:0] core_vector_ff,
    input wire logic        core_push_ff,
    input wire logic [12:0] core_return_ff,
    input wire logic        core_wake_ff
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // A new take pushes and offers the fixed vector.
    chk_take_vector: assert property (
        $rose(core_take_ff) |-> core_push_ff && core_vector_ff == `IRQ_VECTOR)
        else $error("take without push or vector");
    chk_push_single: assert property (
        core_push_ff |=> !core_push_ff) else $error("push longer than one cycle");
    chk_take_holds: assert property (
        core_take_ff && !core_ack |=> core_take_ff) else $error("take dropped early");
    chk_take_release: assert property (
        core_take_ff && core_ack |=> !core_take_ff) else $error("take kept after ack");
    chk_return_pc: assert property (
        $rose(core_take_ff) |-> core_return_ff == $past(core_pc))
        else $error("return address wrong");
    chk_clear_blocks: assert property (
        core_gie_clear |=> !$rose(core_take_ff)) else $error("take after enable clear");
    chk_reset_quiet: assert property (disable iff (1'b0)
        !aresetn |=> !core_take_ff && !core_push_ff && !s_axi_bvalid && !s_axi_rvalid)
        else $error("outputs active in reset");
    chk_wake_single: assert property (
        core_wake_ff |=> !core_wake_ff) else $error("wake longer than one cycle");

    // Main scenarios reached.
    cov_take: cover property ($rose(core_take_ff));
    cov_wake: cover property (core_wake_ff);
    cov_slverr: cover property (s_axi_rvalid && s_axi_rresp == `RESP_SLVERR);
endmodule : irq_ctrl_checker

bind cpu_interrupt_controller irq_ctrl_checker i_irq_ctrl_checker (
    .aclk(aclk), .aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rresp(s_axi_rresp), .core_pc(core_pc),
    .core_gie_clear(core_gie_clear), .core_ack(core_ack), .core_take_ff(core_take_ff),
    .core_vector_ff(core_vector_ff), .core_push_ff(core_push_ff),
    .core_return_ff(core_return_ff), .core_wake_ff(core_wake_ff)
);

`default_nettype wire

/* File: bench/cpu_interrupt_controller_bench.sv */
// Self-checking bench of the interrupt controller.
`timescale 1ns/100ps
`include "irq_ctrl_defines.svh"
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin miscompares++; \
    $display("[FAIL] %0t got %h exp %h", $time, a, e); end end

module cpu_interrupt_controller_bench;
    logic        aclk = 1'b0, aresetn = 1'b0, slow = 1'b0, busy = 1'b0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, ack, take, push, wake, asleep;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic [1:0]  bresp, rresp;
    logic [5:0]  pins = 6'h00;
    logic [9:0]  ev = 10'h000;
    logic [12:0] pc, vec, ret;
    int          miscompares = 0, samples_checked = 0, t0 = 0, lat, take_cnt, pm;
    int          mdl[3];

    always #20 aclk = ~aclk;

    cpu_interrupt_controller i_cpu_interrupt_controller (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .port_pins(pins), .tick_rollover(ev[0]), .periph_events(ev[9:4]),
        .port_op_busy(busy), .core_pc(pc), .core_gie_clear(ev[1]), .core_return_from_isr_instruction(ev[2]),
        .core_sleep(ev[3]), .core_ack(ack), .core_take_ff(take), .core_vector_ff(vec),
        .core_push_ff(push), .core_return_ff(ret), .core_wake_ff(wake),
        .core_asleep_ff(asleep)
    );

    core_seq_model i_core_seq_model (
        .aclk(aclk), .aresetn(aresetn), .slow(slow), .core_take_ff(take),
        .core_ack(ack), .core_pc(pc), .take_cnt(take_cnt)
    );

    // ====================================
    // Bus and event tasks
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!(bvalid && bready));
        bready <= 1'b0;
        `CHK(bresp, `RESP_OKAY)
    endtask : wr

    // The expected value packs the response above the data byte.
    task automatic rd(input logic [7:0] a, input logic [9:0] e);
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!(rvalid && rready));
        rready <= 1'b0;
        `CHK({rresp, rdata[7:0]}, e)
    endtask : rd

    task automatic pulse(input int k);
        @(posedge aclk);
        ev[k] <= 1'b1;
        @(posedge aclk);
        ev <= 10'h000;
        repeat (3) @(posedge aclk);
    endtask : pulse

    task automatic pin(input logic [5:0] v);
        @(posedge aclk);
        pins <= v;
        repeat (6) @(posedge aclk);
    endtask : pin

    task automatic takes(input int n);
        repeat (12) @(posedge aclk);
        `CHK(take_cnt - t0, n)
        t0 = take_cnt;
    endtask : takes

    // Counts cycles until take (0) or wake (1) shows, sampled after the edge settles.
    task automatic wait_hi(input int sel);
        lat = 0;
        while ((sel ? wake : take) !== 1'b1 && lat < 20) begin
            @(posedge aclk);
            #1;
            lat++;
        end
    endtask : wait_hi

    task automatic end_sim;
        if (miscompares == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_sim

    // ====================================
    // Scenarios
    initial begin
        void'($urandom(32'h0062FA2D));
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 8; i++) rd(8'(4 * i), (i == 6) ? 10'h07F : 10'h000);
        rd(8'h20, 10'h200);
        for (int i = 0; i < 6; i++) begin
            mdl[i % 3] = $urandom;
            wr(8'(8 + 4 * (i % 3)), 8'(mdl[i % 3]));
        end
        rd(`OFS_FALL_DETECT_EN, {2'b00, 8'(mdl[0]) & `PIN_MASK});
        rd(`OFS_RISE_DETECT_EN, {2'b00, 8'(mdl[1]) & `PIN_MASK});
        rd(`OFS_PERIPH_IRQ_EN, {2'b00, 8'(mdl[2]) & `PERIPH_MASK});
        wr(`OFS_FALL_DETECT_EN, 8'h00);
        wr(`OFS_RISE_DETECT_EN, 8'h00);
        pulse(0);
        rd(`OFS_IRQ_CONTROL, 10'h004);
        takes(0);
        wr(`OFS_IRQ_CONTROL, 8'h24);
        takes(0);
        wr(`OFS_IRQ_CONTROL, 8'hA4);
        takes(1);
        rd(`OFS_IRQ_CONTROL, 10'h024);
        wr(`OFS_IRQ_CONTROL, 8'h20);
        pulse(2);
        rd(`OFS_IRQ_CONTROL, 10'h0A0);
        pulse(1);
        rd(`OFS_IRQ_CONTROL, 10'h020);
        pulse(0);
        takes(0);
        pulse(2);
        takes(1);
        wr(`OFS_IRQ_CONTROL, 8'h00);
        // Edge pin with rising select and a slow core.
        slow <= 1'b1;
        wr(`OFS_CORE_CONFIG, 8'h40);
        wr(`OFS_IRQ_CONTROL, 8'h90);
        @(posedge aclk);
        pins <= 6'h04;
        wait_hi(0);
        `CHK(lat inside {3, 4}, 1'b1)
        `CHK(vec, `IRQ_VECTOR)
        takes(1);
        rd(`OFS_IRQ_CONTROL, 10'h012);
        wr(`OFS_IRQ_CONTROL, 8'h10);
        pin(6'h00);
        rd(`OFS_IRQ_CONTROL, 10'h010);
        wr(`OFS_CORE_CONFIG, 8'h00);
        pin(6'h04);
        rd(`OFS_IRQ_CONTROL, 10'h010);
        pin(6'h00);
        rd(`OFS_IRQ_CONTROL, 10'h012);
        wr(`OFS_IRQ_CONTROL, 8'h10);
        // Sleep, then wake on a falling pin edge with the global enable clear.
        pin(6'h04);
        pulse(3);
        `CHK(asleep, 1'b1)
        @(posedge aclk);
        pins <= 6'h00;
        wait_hi(1);
        `CHK(lat < 20, 1'b1)
        takes(0);
        wr(`OFS_IRQ_CONTROL, 8'h10);
        wr(`OFS_CORE_CONFIG, 8'h04);
        pin(6'h04);
        rd(`OFS_CORE_STATUS, 10'h000);
        pin(6'h00);
        rd(`OFS_IRQ_CONTROL, 10'h010);
        wr(`OFS_CORE_CONFIG, 8'h00);
        wr(`OFS_RISE_DETECT_EN, 8'h01);
        wr(`OFS_IRQ_CONTROL, 8'h00);
        pin(6'h01);
        rd(`OFS_PIN_CHANGE_FLAGS, 10'h001);
        rd(`OFS_IRQ_CONTROL, 10'h001);
        pin(6'h00);
        wr(`OFS_PIN_CHANGE_FLAGS, 8'h00);
        @(posedge aclk);
        busy <= 1'b1;
        pin(6'h01);
        busy <= 1'b0;
        rd(`OFS_PIN_CHANGE_FLAGS, 10'h000);
        pm = 0;
        for (int i = 0; i < 6; i++) begin
            pulse(4 + i);
            pm |= 1 << ((i < 4) ? i : i + 2);
            rd(`OFS_PERIPH_REQ_FLAGS, 10'(pm));
        end
        wr(`OFS_PERIPH_IRQ_EN, 8'h01);
        wr(`OFS_IRQ_CONTROL, 8'h80);
        takes(0);
        wr(`OFS_IRQ_CONTROL, 8'hC0);
        takes(1);
        wr(`OFS_PERIPH_REQ_FLAGS, 8'h00);
        rd(`OFS_PERIPH_REQ_FLAGS, 10'h000);
        end_sim;
    end

    // Cuts a hang short at 50000 cycles, well beyond the several hundred cycles the run needs.
    initial begin
        #2000000;
        miscompares++;
        end_sim;
    end
endmodule : cpu_interrupt_controller_bench

`default_nettype wire
